// >>> core/pcp_pkg.sv
// package: register map, field layout and reset values of the clock-path control block
package pcp_pkg;
    // register indices; all are word aligned, so each register sits at byte address 4 * index
    localparam logic [11:0] IDX_PLL_CTRL = 12'h010;
    localparam logic [11:0] IDX_PFD_ABP = 12'h017;
    localparam logic [11:0] IDX_VCO_CAL = 12'h018;
    localparam logic [11:0] IDX_VCO_DIV = 12'h1E0;
    localparam logic [11:0] IDX_PATH_SEL = 12'h1E1;
    localparam logic [11:0] IDX_UPDATE = 12'h232;
    localparam logic [11:0] IDX_STATUS = 12'h240;
    localparam logic [11:0] ADDR_PLL_CTRL = IDX_PLL_CTRL << 2;
    localparam logic [11:0] ADDR_PFD_ABP = IDX_PFD_ABP << 2;
    localparam logic [11:0] ADDR_VCO_CAL = IDX_VCO_CAL << 2;
    localparam logic [11:0] ADDR_VCO_DIV = IDX_VCO_DIV << 2;
    localparam logic [11:0] ADDR_PATH_SEL = IDX_PATH_SEL << 2;
    localparam logic [11:0] ADDR_UPDATE = IDX_UPDATE << 2;
    localparam logic [11:0] ADDR_STATUS = IDX_STATUS << 2;

    // register fields: pll control, vco calibration, path select and update
    localparam int PWR_LSB = 0;
    localparam int CPMODE_LSB = 4;
    localparam int POL_BIT = 7;
    localparam int ICP_LSB = 8;
    localparam int CAL_BIT = 0;
    localparam int DIRECT_BIT = 0;
    localparam int VCOSEL_BIT = 1;
    localparam int UPD_BIT = 0;

    localparam logic [1:0] PWR_ON = 2'h0;
    localparam logic [1:0] PWR_DOWN = 2'h1;
    localparam logic [2:0] VDIV_RESET = 3'h2;
    localparam logic [2:0] VDIV_MAX = 3'h4;
    localparam logic [2:0] VDIV_BASE = 3'h2;
    localparam logic [7:0] UPD_CODE = 8'h01;
    localparam logic [1:0] ABP_RESET = 2'h0;
    localparam logic [2:0] ICP_RESET = 3'h7;

    // charge pump modes
    localparam logic [2:0] CP_HIZ = 3'h0;
    localparam logic [2:0] CP_UP = 3'h1;
    localparam logic [2:0] CP_DOWN = 3'h2;
    localparam logic [2:0] CP_NORMAL = 3'h3;
    localparam logic [2:0] CP_RESET = 3'h0;

    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage : pcp_pkg

// >>> core/pcp_pfd.sv
// phase-frequency detector with programmable antibacklash stretch
`timescale 1ns/1ps
`default_nettype none
module pcp_pfd (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ref_edge_i,
    input wire logic fb_edge_i,
    input wire logic [1:0] abp_width_i,
    output logic up_o,
    output logic down_o
);
    logic up_q, up_d, dn_q, dn_d;
    logic [2:0] abp_q, abp_d;

    // a pulse on both lines for abp + 1 cycles before reset kills the dead zone
    always_comb begin
        up_d = up_q | ref_edge_i;
        dn_d = dn_q | fb_edge_i;
        abp_d = abp_q;
        if (up_q && dn_q) begin
            if (abp_q >= {1'b0, abp_width_i}) begin
                up_d = ref_edge_i;
                dn_d = fb_edge_i;
                abp_d = 3'h0;
            end else begin
                abp_d = abp_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
            abp_q <= 3'h0;
        end else begin
            up_q <= up_d;
            dn_q <= dn_d;
            abp_q <= abp_d;
        end
    end

    assign up_o = up_q;
    assign down_o = dn_q;

    chk_pfd_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (up_q && dn_q && abp_q >= {1'b0, abp_width_i} && !ref_edge_i && !fb_edge_i) |=> (!up_q && !dn_q))
        else $error("pfd did not clear after antibacklash");
    chk_pfd_ref_up: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ref_edge_i && !up_q && !dn_q) |=> up_q)
        else $error("reference edge did not pump up");
endmodule : pcp_pfd
`default_nettype wire

// >>> core/pcp_vdiv.sv
// vco divider, ratio 2..6, one-cycle output pulse per period
`timescale 1ns/1ps
`default_nettype none
module pcp_vdiv (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic in_edge_i,
    input wire logic [2:0] ratio_sel_i,
    output logic out_edge_o
);
    logic [2:0] cnt_q, cnt_d;
    logic [2:0] last;
    logic out_q, out_d;

    always_comb begin
        // select 0..4 means divide by 2..6; larger codes clamp to 6
        last = (ratio_sel_i > pcp_pkg::VDIV_MAX) ? pcp_pkg::VDIV_MAX + 3'h1 : ratio_sel_i + 3'h1;
        cnt_d = cnt_q;
        out_d = 1'b0;
        if (in_edge_i) begin
            if (cnt_q >= last) begin
                cnt_d = 3'h0;
                out_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= 3'h0;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign out_edge_o = out_q;

    chk_vdiv_range: assert property (@(posedge clk_i) disable iff (!nrst_i)
        cnt_q <= pcp_pkg::VDIV_MAX + 3'h1)
        else $error("vco divider count out of range");
endmodule : pcp_vdiv
`default_nettype wire

// >>> core/pcp_top.sv
// top: apb register file, update transfer, clock path routing, pll control
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pcp_top (
    input wire logic clk_i,
    input wire logic nrst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // clock path
    input wire logic ext_clk_edge_i,
    input wire logic vco_clk_edge_i,
    input wire logic ref_edge_i,
    input wire logic fb_edge_i,
    output logic dist_clk_edge_o,
    output logic pll_pwrdn_o,
    output logic vco_en_o,
    output logic vco_cal_start_o,
    output logic vco_cal_reset_o,
    output logic pump_up_o,
    output logic pump_down_o,
    output logic pump_hiz_o,
    output logic [2:0] pump_current_setting_o
);
    // ========================================
    // staged and active configuration
    logic [1:0] stg_pwr_q, stg_pwr_d, act_pwr_q, act_pwr_d;
    logic [2:0] stg_cp_q, stg_cp_d, act_cp_q, act_cp_d;
    logic stg_pol_q, stg_pol_d, act_pol_q, act_pol_d;
    logic [2:0] stg_icp_q, stg_icp_d, act_icp_q, act_icp_d;
    logic [1:0] stg_abp_q, stg_abp_d, act_abp_q, act_abp_d;
    logic stg_cal_q, stg_cal_d, act_cal_q, act_cal_d;
    logic [2:0] stg_vdiv_q, stg_vdiv_d, act_vdiv_q, act_vdiv_d;
    logic stg_direct_q, stg_direct_d, act_direct_q, act_direct_d;
    logic stg_vcosel_q, stg_vcosel_d, act_vcosel_q, act_vcosel_d;
    logic upd_pend_q, upd_pend_d;
    logic [31:0] rdata_q, rdata_d;
    logic ready_q, ready_d, err_q, err_d;
    logic cal_start_q, cal_start_d, cal_rst_q, cal_rst_d;
    logic cal_done_once_q, cal_done_once_d;

    logic setup, wr_en, apply;
    assign setup = psel_i && !penable_i;
    assign wr_en = setup && pwrite_i;

    // ========================================
    // apb decode and staging
    // no wait state: answer in the access cycle after setup
    always_comb begin
        stg_pwr_d = stg_pwr_q;
        stg_cp_d = stg_cp_q;
        stg_pol_d = stg_pol_q;
        stg_icp_d = stg_icp_q;
        stg_abp_d = stg_abp_q;
        stg_cal_d = stg_cal_q;
        stg_vdiv_d = stg_vdiv_q;
        stg_direct_d = stg_direct_q;
        stg_vcosel_d = stg_vcosel_q;
        // pending lasts one cycle; a new update write in that cycle wins
        upd_pend_d = 1'b0;
        rdata_d = pcp_pkg::RD_ZERO;
        ready_d = setup;
        err_d = 1'b0;
        if (setup) begin
            case (paddr_i)
                pcp_pkg::ADDR_PLL_CTRL: begin
                    if (pwrite_i) begin
                        stg_pwr_d = pwdata_i[pcp_pkg::PWR_LSB +: 2];
                        stg_cp_d = pwdata_i[pcp_pkg::CPMODE_LSB +: 3];
                        stg_pol_d = pwdata_i[pcp_pkg::POL_BIT];
                        stg_icp_d = pwdata_i[pcp_pkg::ICP_LSB +: 3];
                    end
                    rdata_d[pcp_pkg::PWR_LSB +: 2] = stg_pwr_q;
                    rdata_d[pcp_pkg::CPMODE_LSB +: 3] = stg_cp_q;
                    rdata_d[pcp_pkg::POL_BIT] = stg_pol_q;
                    rdata_d[pcp_pkg::ICP_LSB +: 3] = stg_icp_q;
                end
                pcp_pkg::ADDR_PFD_ABP: begin
                    if (pwrite_i) stg_abp_d = pwdata_i[1:0];
                    rdata_d[1:0] = stg_abp_q;
                end
                pcp_pkg::ADDR_VCO_CAL: begin
                    if (pwrite_i) stg_cal_d = pwdata_i[pcp_pkg::CAL_BIT];
                    rdata_d[pcp_pkg::CAL_BIT] = stg_cal_q;
                end
                pcp_pkg::ADDR_VCO_DIV: begin
                    if (pwrite_i) stg_vdiv_d = pwdata_i[2:0];
                    rdata_d[2:0] = stg_vdiv_q;
                end
                pcp_pkg::ADDR_PATH_SEL: begin
                    if (pwrite_i) begin
                        stg_direct_d = pwdata_i[pcp_pkg::DIRECT_BIT];
                        stg_vcosel_d = pwdata_i[pcp_pkg::VCOSEL_BIT];
                    end
                    rdata_d[pcp_pkg::DIRECT_BIT] = stg_direct_q;
                    rdata_d[pcp_pkg::VCOSEL_BIT] = stg_vcosel_q;
                end
                pcp_pkg::ADDR_UPDATE: begin
                    if (pwrite_i && pwdata_i[7:0] == pcp_pkg::UPD_CODE) upd_pend_d = 1'b1;
                    rdata_d[pcp_pkg::UPD_BIT] = upd_pend_q;
                end
                pcp_pkg::ADDR_STATUS: begin
                    rdata_d[pcp_pkg::PWR_LSB +: 2] = act_pwr_q;
                    rdata_d[pcp_pkg::CPMODE_LSB +: 3] = act_cp_q;
                    rdata_d[pcp_pkg::POL_BIT] = act_pol_q;
                    rdata_d[pcp_pkg::ICP_LSB +: 3] = act_icp_q;
                    rdata_d[12:11] = act_abp_q;
                    rdata_d[13] = act_cal_q;
                    rdata_d[18:16] = act_vdiv_q;
                    rdata_d[20] = act_direct_q;
                    rdata_d[21] = act_vcosel_q;
                    rdata_d[24] = cal_done_once_q;
                end
                default: begin
                    err_d = 1'b1;
                end
            endcase
        end
    end

    // ========================================
    // transfer of staged values on update
    assign apply = upd_pend_q;

    always_comb begin
        act_pwr_d = act_pwr_q;
        act_cp_d = act_cp_q;
        act_pol_d = act_pol_q;
        act_icp_d = act_icp_q;
        act_abp_d = act_abp_q;
        act_cal_d = act_cal_q;
        act_vdiv_d = act_vdiv_q;
        act_direct_d = act_direct_q;
        act_vcosel_d = act_vcosel_q;
        cal_start_d = 1'b0;
        cal_rst_d = 1'b0;
        cal_done_once_d = cal_done_once_q;
        if (apply) begin
            act_pwr_d = stg_pwr_q;
            act_cp_d = stg_cp_q;
            act_pol_d = stg_pol_q;
            act_icp_d = stg_icp_q;
            act_abp_d = stg_abp_q;
            act_cal_d = stg_cal_q;
            act_vdiv_d = stg_vdiv_q;
            act_direct_d = stg_direct_q;
            act_vcosel_d = stg_vcosel_q;
            // calibration starts on a rising edge of the applied bit only
            cal_start_d = stg_cal_q && !act_cal_q;
            cal_rst_d = !stg_cal_q && act_cal_q;
            if (stg_cal_q) cal_done_once_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stg_pwr_q <= pcp_pkg::PWR_DOWN;
            stg_cp_q <= pcp_pkg::CP_RESET;
            stg_pol_q <= 1'b0;
            stg_icp_q <= pcp_pkg::ICP_RESET;
            stg_abp_q <= pcp_pkg::ABP_RESET;
            stg_cal_q <= 1'b0;
            stg_vdiv_q <= pcp_pkg::VDIV_RESET;
            stg_direct_q <= 1'b0;
            stg_vcosel_q <= 1'b0;
            act_pwr_q <= pcp_pkg::PWR_DOWN;
            act_cp_q <= pcp_pkg::CP_RESET;
            act_pol_q <= 1'b0;
            act_icp_q <= pcp_pkg::ICP_RESET;
            act_abp_q <= pcp_pkg::ABP_RESET;
            act_cal_q <= 1'b0;
            act_vdiv_q <= pcp_pkg::VDIV_RESET;
            act_direct_q <= 1'b0;
            act_vcosel_q <= 1'b0;
            upd_pend_q <= 1'b0;
            rdata_q <= pcp_pkg::RD_ZERO;
            ready_q <= 1'b0;
            err_q <= 1'b0;
            cal_start_q <= 1'b0;
            cal_rst_q <= 1'b0;
            cal_done_once_q <= 1'b0;
        end else begin
            stg_pwr_q <= stg_pwr_d;
            stg_cp_q <= stg_cp_d;
            stg_pol_q <= stg_pol_d;
            stg_icp_q <= stg_icp_d;
            stg_abp_q <= stg_abp_d;
            stg_cal_q <= stg_cal_d;
            stg_vdiv_q <= stg_vdiv_d;
            stg_direct_q <= stg_direct_d;
            stg_vcosel_q <= stg_vcosel_d;
            act_pwr_q <= act_pwr_d;
            act_cp_q <= act_cp_d;
            act_pol_q <= act_pol_d;
            act_icp_q <= act_icp_d;
            act_abp_q <= act_abp_d;
            act_cal_q <= act_cal_d;
            act_vdiv_q <= act_vdiv_d;
            act_direct_q <= act_direct_d;
            act_vcosel_q <= act_vcosel_d;
            upd_pend_q <= upd_pend_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q <= err_d;
            cal_start_q <= cal_start_d;
            cal_rst_q <= cal_rst_d;
            cal_done_once_q <= cal_done_once_d;
        end
    end

    // ========================================
    // clock path: source select, divider, bypass
    logic src_edge, vdiv_edge, pfd_up, pfd_dn;
    logic dist_q, dist_d, pwrdn_q, pwrdn_d, vcoen_q, vcoen_d;
    logic pu_q, pu_d, pd_q, pd_d, hiz_q, hiz_d;

    // a powered-down pll leaves the vco silent
    assign src_edge = act_vcosel_q ? (vco_clk_edge_i && act_pwr_q == pcp_pkg::PWR_ON) : ext_clk_edge_i;

    pcp_vdiv u_vdiv (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .in_edge_i(src_edge),
        .ratio_sel_i(act_vdiv_q),
        .out_edge_o(vdiv_edge)
    );

    pcp_pfd u_pfd (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .ref_edge_i(ref_edge_i && act_pwr_q == pcp_pkg::PWR_ON),
        .fb_edge_i(fb_edge_i && act_pwr_q == pcp_pkg::PWR_ON),
        .abp_width_i(act_abp_q),
        .up_o(pfd_up),
        .down_o(pfd_dn)
    );

    always_comb begin
        dist_d = act_direct_q ? src_edge : vdiv_edge;
        pwrdn_d = act_pwr_q != pcp_pkg::PWR_ON;
        vcoen_d = act_vcosel_q && act_pwr_q == pcp_pkg::PWR_ON;
        pu_d = 1'b0;
        pd_d = 1'b0;
        hiz_d = 1'b1;
        if (!pwrdn_d) begin
            case (act_cp_q)
                pcp_pkg::CP_UP: begin
                    pu_d = 1'b1;
                    hiz_d = 1'b0;
                end
                pcp_pkg::CP_DOWN: begin
                    pd_d = 1'b1;
                    hiz_d = 1'b0;
                end
                pcp_pkg::CP_NORMAL: begin
                    // negative polarity swaps the pump direction
                    pu_d = act_pol_q ? pfd_dn : pfd_up;
                    pd_d = act_pol_q ? pfd_up : pfd_dn;
                    hiz_d = 1'b0;
                end
                default: begin
                    hiz_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dist_q <= 1'b0;
            pwrdn_q <= 1'b1;
            vcoen_q <= 1'b0;
            pu_q <= 1'b0;
            pd_q <= 1'b0;
            hiz_q <= 1'b1;
        end else begin
            dist_q <= dist_d;
            pwrdn_q <= pwrdn_d;
            vcoen_q <= vcoen_d;
            pu_q <= pu_d;
            pd_q <= pd_d;
            hiz_q <= hiz_d;
        end
    end

    assign prdata_o = rdata_q;
    assign pready_o = ready_q;
    assign pslverr_o = err_q;
    assign dist_clk_edge_o = dist_q;
    assign pll_pwrdn_o = pwrdn_q;
    assign vco_en_o = vcoen_q;
    assign vco_cal_start_o = cal_start_q;
    assign vco_cal_reset_o = cal_rst_q;
    assign pump_up_o = pu_q;
    assign pump_down_o = pd_q;
    assign pump_hiz_o = hiz_q;
    assign pump_current_setting_o = act_icp_q;

    // ========================================
    // checks
    sequence s_upd_write;
        wr_en && paddr_i == pcp_pkg::ADDR_UPDATE && pwdata_i[7:0] == pcp_pkg::UPD_CODE;
    endsequence

    chk_upd_apply: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_upd_write ##1 1'b1 |=> (act_vdiv_q == $past(stg_vdiv_q)))
        else $error("staged divider not applied after update");
    chk_no_apply: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !upd_pend_q |=> $stable(act_pwr_q) && $stable(act_direct_q))
        else $error("active settings changed without update");
    chk_upd_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (upd_pend_q && !(wr_en && paddr_i == pcp_pkg::ADDR_UPDATE && pwdata_i[7:0] == pcp_pkg::UPD_CODE))
        |=> !upd_pend_q)
        else $error("update bit did not clear itself");
    chk_bypass_path: assert property (@(posedge clk_i) disable iff (!nrst_i)
        act_direct_q |=> dist_q == $past(src_edge))
        else $error("bypass did not pass source edge");
    chk_src_ext: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !act_vcosel_q |-> src_edge == ext_clk_edge_i)
        else $error("external source not selected");
    chk_pwr_down: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (act_pwr_q == pcp_pkg::PWR_DOWN) |=> pll_pwrdn_o && pump_hiz_o && !vco_en_o)
        else $error("pll not powered down");
    chk_cp_forced: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (act_cp_q == pcp_pkg::CP_UP && act_pwr_q == pcp_pkg::PWR_ON) |=> pump_up_o && !pump_down_o)
        else $error("forced pump up not driven");
    chk_pol_swap: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (act_cp_q == pcp_pkg::CP_NORMAL && act_pwr_q == pcp_pkg::PWR_ON && act_pol_q)
        |=> pump_up_o == $past(pfd_dn))
        else $error("negative polarity not applied");
    chk_cal_start: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (apply && stg_cal_q && !act_cal_q) |=> vco_cal_start_o ##1 !vco_cal_start_o)
        else $error("calibration start not one pulse");
    chk_reset_state: assert property (@(posedge clk_i)
        $rose(nrst_i) |-> act_vdiv_q == pcp_pkg::VDIV_RESET && !act_vcosel_q && !act_direct_q)
        else $error("reset configuration wrong");
endmodule : pcp_top
`default_nettype wire

// >>> sim/pcp_far_model.sv
// far-side model: external clock, internal vco, reference and feedback divider edges
`timescale 1ns/1ps
`default_nettype none
module pcp_far_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic vco_en_i,
    output logic ext_clk_edge_o,
    output logic vco_clk_edge_o,
    output logic ref_edge_o,
    output logic fb_edge_o
);
    // ==========
    // edge generators
    logic [1:0] vco_cnt_q;
    logic [3:0] ref_cnt_q;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vco_cnt_q <= 2'h0;
            ref_cnt_q <= 4'h0;
            ext_clk_edge_o <= 1'b0;
            vco_clk_edge_o <= 1'b0;
            ref_edge_o <= 1'b0;
            fb_edge_o <= 1'b0;
        end else begin
            // half rate keeps the bypassed source inside the divider limit
            ext_clk_edge_o <= ~ext_clk_edge_o;
            // vco is unpowered, so silent, until the block enables it
            vco_cnt_q <= (vco_cnt_q == 2'h2 || !vco_en_i) ? 2'h0 : vco_cnt_q + 2'h1;
            vco_clk_edge_o <= vco_en_i && vco_cnt_q == 2'h2;
            ref_cnt_q <= ref_cnt_q + 4'h1;
            ref_edge_o <= ref_cnt_q == 4'h0;
            // feedback lags: a slow vco, so the loop must pump up
            fb_edge_o <= ref_cnt_q == 4'h4;
        end
    end
endmodule // pcp_far_model
`default_nettype wire

// >>> sim/pcp_top_tb.sv
// self-checking bench for the clock-path control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module pcp_top_tb;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, ext_e, vco_e, ref_e, fb_e, dist_o, pwrdn_o, vco_en_o;
    logic cal_start_o, cal_reset_o, up_o, down_o, hiz_o;
    logic [2:0] icp_o;
    logic [33:0] exp_q[$];
    logic [33:0] note;
    logic [31:0] w;
    int miscompares = 0, checked = 0, cycles = 0, seed = 72158, n_start = 0, n_reset = 0;
    int g, both, uonly, donly;
    always #50 clk_i = ~clk_i;
    pcp_top u_pcp_top (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .ext_clk_edge_i(ext_e), .vco_clk_edge_i(vco_e),
        .ref_edge_i(ref_e), .fb_edge_i(fb_e), .dist_clk_edge_o(dist_o), .pll_pwrdn_o(pwrdn_o),
        .vco_en_o(vco_en_o), .vco_cal_start_o(cal_start_o), .vco_cal_reset_o(cal_reset_o),
        .pump_up_o(up_o), .pump_down_o(down_o), .pump_hiz_o(hiz_o), .pump_current_setting_o(icp_o));
    pcp_far_model u_pcp_far_model (.clk_i(clk_i), .nrst_i(nrst_i), .vco_en_i(vco_en_o),
        .ext_clk_edge_o(ext_e), .vco_clk_edge_o(vco_e), .ref_edge_o(ref_e), .fb_edge_o(fb_e));
    // ==========
    // apb master; every transfer leaves a note {check data, slverr, data}
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic err);
        int n;
        n = 0;
        exp_q.push_back({!wr, err, e});
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (pready_o !== 1'b1) miscompares++;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0000_0000, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, e, 1'b0);
    endtask
    task automatic upd();
        wr(pcp_pkg::ADDR_UPDATE, 32'h0000_0001);
        repeat (4) @(posedge clk_i);
    endtask
    task automatic gap(output int n);
        n = 0;
        while (dist_o !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        @(posedge clk_i);
        n = 1;
        while (dist_o !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    task automatic summarize();
        if (exp_q.size() != 0) miscompares++;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ==========
    // monitor: oldest note against each completed transfer
    always @(posedge clk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1) begin
            note = exp_q.pop_front();
            `CHK("pslverr", note[32], pslverr_o)
            if (note[33]) `CHK("prdata", note[31:0], prdata_o)
        end
        if (cal_start_o === 1'b1) n_start++;
        if (cal_reset_o === 1'b1) n_reset++;
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        `CHK("reset pins", 6'b10_1111, {pwrdn_o, vco_en_o, hiz_o, icp_o})
        rd(pcp_pkg::ADDR_PLL_CTRL, 32'h0000_0701);
        rd(pcp_pkg::ADDR_VCO_DIV, 32'h0000_0002);
        rd(pcp_pkg::ADDR_STATUS, 32'h0002_0701);
        apb(1'b0, 12'h300, 32'h0, 32'h0000_0000, 1'b1);
        gap(g);
        `CHK("reset divider gap", 8, g)
        $display("test reset done");
        // staged values stay inactive until the update code is written
        wr(pcp_pkg::ADDR_PATH_SEL, 32'h0000_0003);
        wr(pcp_pkg::ADDR_PLL_CTRL, 32'h0000_0530);
        wr(pcp_pkg::ADDR_UPDATE, 32'h0000_0002);
        repeat (4) @(posedge clk_i);
        rd(pcp_pkg::ADDR_STATUS, 32'h0002_0701);
        `CHK("pwrdn staged", 1'b1, pwrdn_o)
        upd();
        `CHK("active pins", 6'b01_0101, {pwrdn_o, vco_en_o, hiz_o, icp_o})
        rd(pcp_pkg::ADDR_UPDATE, 32'h0000_0000);
        rd(pcp_pkg::ADDR_STATUS, 32'h0032_0530);
        gap(g);
        `CHK("vco bypass gap", 3, g)
        $display("test update done");
        wr(pcp_pkg::ADDR_PATH_SEL, 32'h0000_0000);
        for (int c = 0; c < 5; c++) begin
            wr(pcp_pkg::ADDR_VCO_DIV, 32'(c));
            upd();
            gap(g);
            `CHK("divided gap", 2 * (c + 2), g)
        end
        wr(pcp_pkg::ADDR_PATH_SEL, 32'h0000_0001);
        upd();
        gap(g);
        `CHK("bypass gap", 2, g)
        $display("test path done");
        // the last pass uses unused code 5, which must fall back to high impedance
        for (int m = 0; m < 4; m++) begin
            wr(pcp_pkg::ADDR_PLL_CTRL, 32'h0000_0500 | (32'(m + 2 * (m / 3)) << 4));
            upd();
            `CHK("forced pump", (m == 1) ? 3'b010 : (m == 2) ? 3'b001 : 3'b100, {hiz_o, up_o, down_o})
        end
        for (int pol = 0; pol < 2; pol++) begin
            w = $random(seed);
            wr(pcp_pkg::ADDR_PFD_ABP, w);
            rd(pcp_pkg::ADDR_PFD_ABP, w & 32'h0000_0003);
            wr(pcp_pkg::ADDR_PLL_CTRL, 32'h0000_0530 | (32'(pol) << 7));
            upd();
            while (ref_e !== 1'b1) @(posedge clk_i);
            both = 0;
            uonly = 0;
            donly = 0;
            repeat (64) begin
                @(posedge clk_i);
                both += (up_o === 1'b1 && down_o === 1'b1);
                uonly += (up_o === 1'b1 && down_o === 1'b0);
                donly += (up_o === 1'b0 && down_o === 1'b1);
            end
            `CHK("antibacklash", 4 * (int'(w[1:0]) + 1), both)
            `CHK("pump direction", pol == 0, uonly > donly)
        end
        $display("test pump done");
        wr(pcp_pkg::ADDR_VCO_CAL, 32'h0000_0001);
        upd();
        upd();
        `CHK("cal start", 2'b10, {n_start == 1, n_reset == 1})
        wr(pcp_pkg::ADDR_VCO_CAL, 32'h0000_0000);
        upd();
        wr(pcp_pkg::ADDR_VCO_CAL, 32'h0000_0001);
        upd();
        `CHK("cal restart", 2'b11, {n_start == 2, n_reset == 1})
        rd(pcp_pkg::ADDR_STATUS, 32'h0114_25B0 | (32'(w[1:0]) << 11));
        $display("test calibration done");
        summarize();
    end
endmodule // pcp_top_tb
`default_nettype wire
